// File: core/phyirq_ctrl.sv
// Interrupt control/status register with enables, flags and irq output
// Notes on behaviour
// - Bit 15 enables jabber interrupt, resets zero
// - Bit 14 enables receive error interrupt
// - Bit 13 enables page received interrupt
// - Bit 12 enables parallel detect fault interrupt
// - Bit 11 enables partner acknowledge interrupt
// - Bit 10 enables link down interrupt
// - Bit 9 enables remote fault interrupt
// - Bit 6 flags receive error, read only, clears on read
// - Bit 5 flags new page, clears on read
// - Bit 4 flags parallel detect fault
// - Bit 8 enables link up interrupt
`timescale 1ns/1ps
`default_nettype none
module phyirq_ctrl
   import phyirq_pkg::*;
(
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [4:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [7:0] event_in,
   output logic [15:0] reg_rdata_out,
   output logic irq_out
);
   logic [7:0] enable;
   wire logic [7:0] flags;
   wire logic sel;
   wire logic do_wr;
   wire logic do_rd;
   wire logic [15:0] reg_view;
   wire logic [7:0] next_enable;
   wire logic [7:0] next_flags_view;
   wire logic next_irq;
   wire logic [7:0] pending;
   // Named enable fields, high byte of the register
   wire logic en_jabber;
   wire logic en_rxerr;
   wire logic en_page;
   wire logic en_pdf;
   wire logic en_lpack;
   wire logic en_ldown;
   wire logic en_rfault;
   wire logic en_lup;
   // Named event flags, low byte; flag n pairs with enable n
   wire logic st_jabber;
   wire logic st_rxerr;
   wire logic st_page;
   wire logic st_pdf;
   wire logic st_lpack;
   wire logic st_ldown;
   wire logic st_rfault;
   wire logic st_lup;

   assign sel = (reg_addr_in == PHYIRQ_REG_ADDR);
   assign do_wr = sel & reg_wr_in;
   assign do_rd = sel & reg_rd_in;
   assign reg_view = {enable, flags};
   assign pending = flags & enable;

   assign en_jabber = enable[PHYIRQ_EN_JABBER - PHYIRQ_EN_LSB];
   assign en_rxerr = enable[PHYIRQ_EN_RXERR - PHYIRQ_EN_LSB];
   assign en_page = enable[PHYIRQ_EN_PAGE - PHYIRQ_EN_LSB];
   assign en_pdf = enable[PHYIRQ_EN_PDF - PHYIRQ_EN_LSB];
   assign en_lpack = enable[PHYIRQ_EN_LPACK - PHYIRQ_EN_LSB];
   assign en_ldown = enable[PHYIRQ_EN_LDOWN - PHYIRQ_EN_LSB];
   assign en_rfault = enable[PHYIRQ_EN_RFAULT - PHYIRQ_EN_LSB];
   assign en_lup = enable[PHYIRQ_EN_LUP - PHYIRQ_EN_LSB];

   assign st_jabber = flags[PHYIRQ_EN_JABBER - PHYIRQ_EN_LSB];
   assign st_rxerr = flags[PHYIRQ_ST_RXERR];
   assign st_page = flags[PHYIRQ_ST_PAGE];
   assign st_pdf = flags[PHYIRQ_ST_PDF];
   assign st_lpack = flags[PHYIRQ_EN_LPACK - PHYIRQ_EN_LSB];
   assign st_ldown = flags[PHYIRQ_EN_LDOWN - PHYIRQ_EN_LSB];
   assign st_rfault = flags[PHYIRQ_EN_RFAULT - PHYIRQ_EN_LSB];
   assign st_lup = flags[PHYIRQ_EN_LUP - PHYIRQ_EN_LSB];

   // Flags are read only; writes to the low byte are dropped
   genvar g;
   generate
      for (g = 0; g < PHYIRQ_NUM_EVT; g++) begin : g_flag
         phyirq_flag u_flag (
            .mclk_in(mclk_in),
            .nrst_in(nrst_in),
            .event_in(event_in[g]),
            .clear_in(do_rd),
            .flag_out(flags[g])
         );
      end
   endgenerate

   // Irq is registered, so use the next flag value to keep irq in step with flags
   assign next_flags_view = event_in | (flags & {8{~do_rd}});
   assign next_enable = do_wr ? reg_wdata_in[15:8] : enable;
   assign next_irq = |(next_flags_view & next_enable);

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         enable <= PHYIRQ_EN_RESET;
      end else if (do_wr) begin
         enable <= reg_wdata_in[15:8];
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= {PHYIRQ_EN_RESET, PHYIRQ_ST_RESET};
         irq_out <= 1'b0;
      end else begin
         // Read data is captured in the read cycle, before the clear lands
         if (do_rd) begin
            reg_rdata_out <= reg_view;
         end
         irq_out <= next_irq;
      end
   end

   // Irq is the registered OR of enabled flags
   a_irq_follows: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      irq_out == |pending)
      else $error("irq output disagrees with enabled flags");
   a_all_masked: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      enable == 8'h00 |-> !irq_out)
      else $error("irq with all sources disabled");
   a_ldown_mask: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      !en_ldown && st_ldown && pending == 8'h00 |-> !irq_out)
      else $error("masked link down raised irq");
   a_reset_clean: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      $rose(nrst_in) |-> enable == PHYIRQ_EN_RESET && flags == PHYIRQ_ST_RESET)
      else $error("register not clear after reset");

   // Flags: set wins over the clearing read
   a_read_clears: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_rd && !event_in[PHYIRQ_ST_PAGE] |=> !st_page)
      else $error("page flag not cleared by read");
   a_set_wins: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_rd && event_in[PHYIRQ_ST_PAGE] |=> st_page)
      else $error("page event in read cycle lost");
   a_other_addr: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      reg_rd_in && !sel |=> (flags & $past(flags)) == $past(flags))
      else $error("flags cleared by read of another address");
   a_page_set: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      event_in[PHYIRQ_ST_PAGE] |=> st_page)
      else $error("page event lost");
   a_rxerr_set: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      event_in[PHYIRQ_ST_RXERR] |=> st_rxerr)
      else $error("receive error event lost");
   a_rxerr_clear: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_rd && !event_in[PHYIRQ_ST_RXERR] |=> !st_rxerr)
      else $error("receive error flag not cleared by read");
   a_pdf_set: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      event_in[PHYIRQ_ST_PDF] |=> st_pdf)
      else $error("fault event lost");
   a_pdf_hold: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      st_pdf && !do_rd |=> st_pdf)
      else $error("fault flag dropped without read");

   // Read data
   a_read_data: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_rd |=> reg_rdata_out == {$past(enable), $past(flags)})
      else $error("read data wrong");
   a_rdata_hold: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      !do_rd |=> $stable(reg_rdata_out))
      else $error("read data changed without read");

   // Enables
   a_enable_write: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_wr |=> enable == $past(reg_wdata_in[15:8]))
      else $error("enable byte not written");
   a_enable_hold: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      !do_wr |=> $stable(enable))
      else $error("enable changed without write");
   a_jabber_wr: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_wr |=> en_jabber == $past(reg_wdata_in[PHYIRQ_EN_JABBER]))
      else $error("jabber enable not written");
   a_rxerr_wr: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_wr |=> en_rxerr == $past(reg_wdata_in[PHYIRQ_EN_RXERR]))
      else $error("receive error enable not written");
   a_page_wr: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_wr |=> en_page == $past(reg_wdata_in[PHYIRQ_EN_PAGE]))
      else $error("page enable not written");
   a_pdf_wr: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_wr |=> en_pdf == $past(reg_wdata_in[PHYIRQ_EN_PDF]))
      else $error("fault enable not written");
   a_lpack_wr: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_wr |=> en_lpack == $past(reg_wdata_in[PHYIRQ_EN_LPACK]))
      else $error("partner acknowledge enable not written");
   a_ldown_wr: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_wr |=> en_ldown == $past(reg_wdata_in[PHYIRQ_EN_LDOWN]))
      else $error("link down enable not written");
   a_rfault_wr: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_wr |=> en_rfault == $past(reg_wdata_in[PHYIRQ_EN_RFAULT]))
      else $error("remote fault enable not written");
   a_lup_wr: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      do_wr |=> en_lup == $past(reg_wdata_in[PHYIRQ_EN_LUP]))
      else $error("link up enable not written");

   // Each enabled source drives the irq on its own
   a_jabber_irq: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      st_jabber && en_jabber |-> irq_out)
      else $error("enabled jabber flag without irq");
   a_rxerr_irq: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      st_rxerr && en_rxerr |-> irq_out)
      else $error("enabled receive error flag without irq");
   a_page_irq: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      st_page && en_page |-> irq_out)
      else $error("enabled page flag without irq");
   a_pdf_irq: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      st_pdf && en_pdf |-> irq_out)
      else $error("enabled fault flag without irq");
   a_lpack_irq: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      st_lpack && en_lpack |-> irq_out)
      else $error("enabled partner acknowledge flag without irq");
   a_ldown_irq: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      st_ldown && en_ldown |-> irq_out)
      else $error("enabled link down flag without irq");
   a_rfault_irq: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      st_rfault && en_rfault |-> irq_out)
      else $error("enabled remote fault flag without irq");
   a_lup_irq: assert property (@(posedge mclk_in)
      disable iff (!nrst_in)
      st_lup && en_lup |-> irq_out)
      else $error("enabled link up flag without irq");
endmodule : phyirq_ctrl
`default_nettype wire

// File: core/phyirq_flag.sv
// One sticky event flag, cleared by a register read
`timescale 1ns/1ps
`default_nettype none
module phyirq_flag (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic event_in,
   input wire logic clear_in,
   output logic flag_out
);
   wire logic next_flag;
   // A new event in the clearing cycle survives the clear
   assign next_flag = event_in | (flag_out & ~clear_in);
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flag_out <= 1'b0;
      end else begin
         flag_out <= next_flag;
      end
   end
endmodule : phyirq_flag
`default_nettype wire

// File: core/phyirq_pkg.sv
// Register map and constants of the interrupt control/status register
package phyirq_pkg;
   localparam logic [4:0] PHYIRQ_REG_ADDR = 5'h1B;
   localparam int PHYIRQ_EN_JABBER = 15;
   localparam int PHYIRQ_EN_RXERR = 14;
   localparam int PHYIRQ_EN_PAGE = 13;
   localparam int PHYIRQ_EN_PDF = 12;
   localparam int PHYIRQ_EN_LPACK = 11;
   localparam int PHYIRQ_EN_LDOWN = 10;
   localparam int PHYIRQ_EN_RFAULT = 9;
   localparam int PHYIRQ_EN_LUP = 8;
   localparam int PHYIRQ_EN_LSB = 8;
   localparam int PHYIRQ_NUM_EVT = 8;
   localparam int PHYIRQ_ST_RXERR = 6;
   localparam int PHYIRQ_ST_PAGE = 5;
   localparam int PHYIRQ_ST_PDF = 4;
   localparam logic [7:0] PHYIRQ_EN_RESET = 8'h00;
   localparam logic [7:0] PHYIRQ_ST_RESET = 8'h00;
endpackage : phyirq_pkg

// File: tb/phyirq_ctrl_bench.sv
// Self-checking bench of the interrupt control/status register
`timescale 1ns/1ps
`default_nettype none
module phyirq_ctrl_bench;
   import phyirq_pkg::*;
   logic mclk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [4:0] addr = 5'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] wd = 16'h0000;
   logic [7:0] ev = 8'h00;
   logic [7:0] m;
   logic [15:0] rdata;
   logic irq;
   int err_count = 0;
   int total_checks = 0;
   always #25 mclk_in = ~mclk_in;
   phyirq_ctrl DUT (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wd), .event_in(ev), .reg_rdata_out(rdata),
      .irq_out(irq));
   task automatic tick;
      @(posedge mclk_in);
      #5;
   endtask : tick
   task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t read %h expected %h", $time, g, e);
      end
   endtask : chk_reg
   task automatic chk_irq(input logic e);
      total_checks++;
      if (irq !== e) begin
         err_count++;
         $display("[FAIL] %0t irq %b expected %b", $time, irq, e);
      end
   endtask : chk_irq
   task automatic wreg(input logic [4:0] a, input logic [15:0] d);
      tick();
      addr = a;
      wd = d;
      wr = 1'b1;
      tick();
      wr = 1'b0;
   endtask : wreg
   // Optional event in the read cycle and optional other address
   task automatic rreg(input logic [15:0] e, input logic [7:0] v = 8'h00,
      input logic [4:0] a = PHYIRQ_REG_ADDR);
      tick();
      addr = a;
      rd = 1'b1;
      ev = v;
      tick();
      rd = 1'b0;
      ev = 8'h00;
      chk_reg(rdata, e);
   endtask : rreg
   // Event held one cycle, then one idle cycle; the registered irq is already set with the flag
   task automatic pulse(input logic [7:0] e);
      tick();
      ev = e;
      tick();
      ev = 8'h00;
      tick();
   endtask : pulse
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   initial begin
      #50000;
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (10) @(posedge mclk_in);
      #5 nrst_in = 1'b1;
      rreg(16'h0000);
      chk_irq(1'b0);
      wreg(PHYIRQ_REG_ADDR, 16'hFFFF);
      wreg(5'h00, 16'h0000);
      rreg(16'hFF00);
      $display("test reset and write done");
      // Each enable alone: only its own flag may raise irq
      for (int i = 0; i < 8; i++) begin
         m = 8'h01 << i;
         wreg(PHYIRQ_REG_ADDR, {m, 8'hFF});
         pulse(~m);
         chk_irq(1'b0);
         rreg({m, ~m});
         pulse(m);
         chk_irq(1'b1);
         rreg({m, m});
         tick();
         chk_irq(1'b0);
         rreg({m, 8'h00});
      end
      $display("test per source done");
      // Event in the read cycle survives the clear
      wreg(PHYIRQ_REG_ADDR, 16'h2000);
      pulse(8'h20);
      rreg(16'h2020, 8'h20);
      chk_irq(1'b1);
      rreg(16'h2020, 8'h00, 5'h00);
      rreg(16'h2020);
      chk_irq(1'b0);
      rreg(16'h2000);
      $display("test read race done");
      // Reset in mid-run clears enables, flags and outputs
      wreg(PHYIRQ_REG_ADDR, 16'hFF00);
      pulse(8'hFF);
      chk_irq(1'b1);
      nrst_in = 1'b0;
      repeat (3) tick();
      chk_irq(1'b0);
      chk_reg(rdata, 16'h0000);
      nrst_in = 1'b1;
      rreg(16'h0000);
      chk_irq(1'b0);
      $display("test reset in run done");
      print_verdict();
   end
endmodule : phyirq_ctrl_bench
`default_nettype wire
